// ### ccdr_if.sv
/*
 * Interface carrying digitised samples from the front end into the readout buffer.
 * Assumes one clock shared by both ends; valid/ready handshake on each side.
 */
`default_nettype none
interface ccdr_if #(parameter int W = 12) ();
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input  ready);
    modport dst (input  data, input  valid, output ready);
endinterface
`default_nettype wire

// ### ccdr_pkg.sv
/*
 * Constants for the frame-transfer sensor drive sequencer.
 * Assumes a 25 MHz ref_clk.
 */
`default_nettype none
package ccdr_pkg;
    localparam int CLK_MHZ        = 25;
    localparam int CLEAR_MIN_NS   = 1000;
    localparam int CLEAR_CYC      = (CLEAR_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int LINES          = 500;
    localparam int PIXELS         = 680;
    localparam int DARK_COLS      = 22;
    localparam int DARK_LINES     = 4;
    localparam int DUMMY_ELEMS    = 4;
    localparam int XFER_FIELD1    = 500;
    localparam int XFER_FIELD2    = 501;
    localparam int INTEG_DEFAULT  = 1000;
    // Cycles from the pixel's start (the cycle before its reset pulse) to taking its sample:
    // reset, shift, sensor output, then two synchroniser stages
    localparam int PIX_SAMPLE_CYC = 5;
    localparam logic [1:0] MODE_INTERLACE = 2'h0;
    localparam logic [1:0] MODE_PROG_ONE  = 2'h1;
    localparam logic [1:0] MODE_PROG_DUAL = 2'h2;
    localparam logic [1:0] MODE_LINE_SUM  = 2'h3;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_CLEAR = 7'h02,
        ST_INTEG = 7'h04,
        ST_SUM   = 7'h08,
        ST_XFER  = 7'h10,
        ST_LINE  = 7'h20,
        ST_PIX   = 7'h40
    } ccdr_state_e;
endpackage
`default_nettype wire

// ### ccdr_buf.sv
/*
 * Two-entry buffer for sample pairs.
 * Assumes single clock, synchronous active-high reset.
 */
`default_nettype none
module ccdr_buf #(
    parameter int W = 24
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    ccdr_if.dst       in_p,
    ccdr_if.src       out_p
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic         wp_q, wp_d, rp_q, rp_d;
    logic [1:0]   cnt_q, cnt_d;
    logic         push, pop;

    always_comb begin
        push     = in_p.valid && (cnt_q != 2'h2);
        pop      = out_p.ready && (cnt_q != 2'h0);
        mem_d    = mem_q;
        wp_d     = wp_q;
        rp_d     = rp_q;
        cnt_d    = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_p.data;
            wp_d        = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        mem_q <= mem_d;
    end

    assign in_p.ready  = (cnt_q != 2'h2);
    assign out_p.valid = (cnt_q != 2'h0);
    assign out_p.data  = mem_q[rp_q];
endmodule
`default_nettype wire

// ### ccdr_ctrl.sv
/*
 * Timing generator for a frame-transfer CCD: clear, integrate, parallel
 * transfer, serial readout; samples from an external converter are tagged
 * and buffered. Assumes converter samples are asynchronous to ref_clk.
 */
// Functional notes
// - Clear pulse on overflow drain lasts at least one microsecond.
// - Interlaced mode issues 500 transfer pulses field one, 501 field two.
// - Interlaced and single-register progressive read video from register two.
// - Dual-register progressive clocks both registers together, two lines in parallel.
// - Line-summing pulses precede the parallel transfer into storage.
// - In line summing, register one may be read for smear subtraction.
// - Reset gate pulsed once per pixel before next charge arrives.
// - Storage gate pulsed with serial gate to move one line.
// - Overflow drain dips during parallel transfer.
`default_nettype none
module ccdr_ctrl #(
    parameter int AW       = 12,
    parameter int LINES    = ccdr_pkg::LINES,
    parameter int PIXELS   = ccdr_pkg::PIXELS,
    parameter int INTEG_CY = ccdr_pkg::INTEG_DEFAULT
) (
    input  wire logic          ref_clk,
    input  wire logic          srst,
    input  wire logic          frame_start,
    input  wire logic [1:0]    mode_sel,
    input  wire logic [AW-1:0] adc_a,
    input  wire logic [AW-1:0] adc_b,
    input  wire logic          out_ready,
    output logic               image_gate_a,
    output logic               image_gate_b,
    output logic               storage_gate,
    output logic               serial_shift_gate,
    output logic               reset_gate,
    output logic               drain_clear,
    output logic               drain_dip,
    output logic               out_valid,
    output logic [AW-1:0]      out_video,
    output logic [AW-1:0]      out_aux,
    output logic               out_dark,
    output logic               out_line_start,
    output logic               busy
);
    localparam int LW = 10;
    localparam int PW = 10;
    localparam int CW = 16;
    localparam int DW = 2 * AW + 2;

    ccdr_pkg::ccdr_state_e st_q, st_d;
    logic [1:0]    mode_q, mode_d;
    logic          field_q, field_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [LW-1:0] line_q, line_d;
    logic [PW-1:0] pix_q, pix_d;
    logic          ph_q, ph_d;
    logic          iga_d, igb_d, sg_d, ssg_d, rg_d, dc_d, dd_d;
    logic          iga_q, igb_q, sg_q, ssg_q, rg_q, dc_q, dd_q;
    logic          push_ok, samp;
    logic [AW-1:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;

    ccdr_if #(.W(DW)) in_b ();
    ccdr_if #(.W(DW)) out_b ();

    ////////////////////////////////////////////////////////////////////////
    // Converter inputs come from another domain; two stages each
    always_ff @(posedge ref_clk) begin
        a_s1_q <= adc_a;
        a_s2_q <= a_s1_q;
        b_s1_q <= adc_b;
        b_s2_q <= b_s1_q;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d    = st_q;
        mode_d  = mode_q;
        field_d = field_q;
        cnt_d   = cnt_q;
        line_d  = line_q;
        pix_d   = pix_q;
        ph_d    = ~ph_q;
        iga_d   = 1'b0;
        igb_d   = 1'b0;
        sg_d    = 1'b0;
        ssg_d   = 1'b0;
        rg_d    = 1'b0;
        dc_d    = 1'b0;
        dd_d    = 1'b0;
        samp    = 1'b0;
        case (st_q)
            ccdr_pkg::ST_IDLE: begin
                if (frame_start) begin
                    mode_d = mode_sel;
                    st_d   = ccdr_pkg::ST_CLEAR;
                    cnt_d  = '0;
                end
            end
            ccdr_pkg::ST_CLEAR: begin
                dc_d  = 1'b1;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CW'(ccdr_pkg::CLEAR_CYC - 1)) begin
                    cnt_d = '0;
                    st_d  = ccdr_pkg::ST_INTEG;
                end
            end
            ccdr_pkg::ST_INTEG: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == CW'(INTEG_CY - 1)) begin
                    cnt_d = '0;
                    ph_d  = 1'b0;
                    st_d  = (mode_q == ccdr_pkg::MODE_LINE_SUM) ? ccdr_pkg::ST_SUM
                                                                : ccdr_pkg::ST_XFER;
                end
            end
            ccdr_pkg::ST_SUM: begin
                iga_d = !field_q;
                igb_d = field_q;
                if (ph_q) begin
                    ph_d = 1'b0;
                    st_d = ccdr_pkg::ST_XFER;
                end
            end
            ccdr_pkg::ST_XFER: begin
                dd_d  = 1'b1;
                iga_d = !ph_q;
                igb_d = !ph_q;
                sg_d  = !ph_q;
                ssg_d = !ph_q;
                if (ph_q) begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CW'((field_q ? LINES + (ccdr_pkg::XFER_FIELD2 -
                                                         ccdr_pkg::XFER_FIELD1)
                                              : LINES) - 1)) begin
                        dd_d   = 1'b0;
                        cnt_d  = '0;
                        line_d = '0;
                        st_d   = ccdr_pkg::ST_LINE;
                    end
                end
            end
            ccdr_pkg::ST_LINE: begin
                sg_d  = !ph_q;
                ssg_d = !ph_q;
                pix_d = '0;
                if (ph_q) begin
                    st_d = ccdr_pkg::ST_PIX;
                end
            end
            ccdr_pkg::ST_PIX: begin
                // dummies clocked first
                // Stall only before a pixel starts, so the sample is always
                // taken a fixed latency after its shift and finds buffer room
                ph_d  = ph_q;
                cnt_d = cnt_q + 1'b1;
                rg_d  = (cnt_q == '0) && push_ok;
                ssg_d = (cnt_q == CW'(1));
                if ((cnt_q == '0) && !push_ok) begin
                    cnt_d = '0;
                end
                if (cnt_q == CW'(ccdr_pkg::PIX_SAMPLE_CYC)) begin
                    samp  = 1'b1;
                    cnt_d = '0;
                    pix_d = pix_q + 1'b1;
                    if (pix_q == PW'(PIXELS + ccdr_pkg::DUMMY_ELEMS - 1)) begin
                        line_d = line_q + 1'b1;
                        st_d   = ccdr_pkg::ST_LINE;
                        if (mode_q == ccdr_pkg::MODE_PROG_DUAL) begin
                            line_d = line_q + LW'(2);
                        end
                        if (line_d >= LW'(LINES + ccdr_pkg::DARK_LINES)) begin
                            field_d = ~field_q;
                            st_d    = ccdr_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: st_d = ccdr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q    <= ccdr_pkg::ST_IDLE;
            mode_q  <= ccdr_pkg::MODE_INTERLACE;
            field_q <= 1'b0;
            cnt_q   <= '0;
            line_q  <= '0;
            pix_q   <= '0;
            ph_q    <= 1'b0;
            iga_q   <= 1'b0;
            igb_q   <= 1'b0;
            sg_q    <= 1'b0;
            ssg_q   <= 1'b0;
            rg_q    <= 1'b0;
            dc_q    <= 1'b0;
            dd_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            mode_q  <= mode_d;
            field_q <= field_d;
            cnt_q   <= cnt_d;
            line_q  <= line_d;
            pix_q   <= pix_d;
            ph_q    <= ph_d;
            iga_q   <= iga_d;
            igb_q   <= igb_d;
            sg_q    <= sg_d;
            ssg_q   <= ssg_d;
            rg_q    <= rg_d;
            dc_q    <= dc_d;
            dd_q    <= dd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample tagging; pixel shifting stalls while the buffer is full
    logic valid_pix, dark_pix, first_pix;
    always_comb begin
        push_ok   = in_b.ready;
        valid_pix = pix_q >= PW'(ccdr_pkg::DUMMY_ELEMS);
        dark_pix  = pix_q < PW'(ccdr_pkg::DUMMY_ELEMS + ccdr_pkg::DARK_COLS);
        first_pix = pix_q == PW'(ccdr_pkg::DUMMY_ELEMS);
        in_b.valid = samp && valid_pix;
        in_b.data  = {dark_pix, first_pix, b_s2_q,
                      (mode_q == ccdr_pkg::MODE_INTERLACE ||
                       mode_q == ccdr_pkg::MODE_PROG_ONE) ? AW'(0) : a_s2_q};
    end

    ccdr_buf #(.W(DW)) u_buf (
        .ref_clk (ref_clk),
        .srst    (srst),
        .in_p    (in_b),
        .out_p   (out_b)
    );

    ////////////////////////////////////////////////////////////////////////
    logic ov_q, os_q, od_q;
    logic [AW-1:0] vid_q, aux_q;
    logic          take;
    always_comb begin
        take = !ov_q || out_ready;
        out_b.ready = take;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ov_q  <= 1'b0;
            os_q  <= 1'b0;
            od_q  <= 1'b0;
            vid_q <= '0;
            aux_q <= '0;
        end else if (take) begin
            ov_q  <= out_b.valid;
            od_q  <= out_b.data[DW-1];
            os_q  <= out_b.data[DW-2];
            vid_q <= out_b.data[2*AW-1:AW];
            aux_q <= out_b.data[AW-1:0];
        end
    end

    assign image_gate_a      = iga_q;
    assign image_gate_b      = igb_q;
    assign storage_gate      = sg_q;
    assign serial_shift_gate = ssg_q;
    assign reset_gate        = rg_q;
    assign drain_clear       = dc_q;
    assign drain_dip         = dd_q;
    assign out_valid         = ov_q;
    assign out_video         = vid_q;
    assign out_aux           = aux_q;
    assign out_dark          = od_q;
    assign out_line_start    = os_q;
    assign busy              = (st_q != ccdr_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ### ccdr_ctrl_checker.sv
/*
 * Port checker for the sensor drive sequencer.
 * Assumes it is bound onto every ccdr_ctrl instance.
 */
`default_nettype none
module ccdr_ctrl_checker #(
    parameter int AW = 12
) (
    input wire logic          ref_clk,
    input wire logic          srst,
    input wire logic          frame_start,
    input wire logic [1:0]    mode_sel,
    input wire logic          out_ready,
    input wire logic          image_gate_a,
    input wire logic          storage_gate,
    input wire logic          serial_shift_gate,
    input wire logic          reset_gate,
    input wire logic          drain_clear,
    input wire logic          drain_dip,
    input wire logic          out_valid,
    input wire logic [AW-1:0] out_video,
    input wire logic [AW-1:0] out_aux,
    input wire logic          busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [5:0] clr_q;
    logic       rst_q;
    logic [1:0] mode_q;
    // Mode is tracked here because mode_sel may move mid-frame
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clr_q  <= 6'h00;
            rst_q  <= 1'b0;
            mode_q <= 2'h0;
        end else begin
            clr_q <= drain_clear ? clr_q + 6'h01 : 6'h00;
            if (reset_gate) rst_q <= 1'b1;
            else if (serial_shift_gate && !storage_gate) rst_q <= 1'b0;
            if (frame_start && !busy) mode_q <= mode_sel;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_clear_len; $fell(drain_clear) |-> clr_q == ccdr_pkg::CLEAR_CYC; endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear pulse length wrong");
    property p_start; frame_start && !busy |-> ##[1:2] $rose(drain_clear); endproperty
    a_start: assert property (p_start) else $error("frame did not begin with clear");
    property p_no_overlap; drain_clear |-> !image_gate_a && !storage_gate; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("clear overlaps transfer");
    property p_dip; image_gate_a && storage_gate |-> drain_dip; endproperty
    a_dip: assert property (p_dip) else $error("no drain dip in transfer");
    property p_line_move; storage_gate |-> serial_shift_gate; endproperty
    a_line_move: assert property (p_line_move) else $error("storage gate alone");
    property p_node_reset; $rose(serial_shift_gate) && !storage_gate |-> rst_q; endproperty
    a_node_reset: assert property (p_node_reset) else $error("pixel without reset");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_video); endproperty
    a_hold: assert property (p_hold) else $error("output word dropped in stall");
    property p_aux; out_valid && mode_q < 2'h2 |-> out_aux == '0; endproperty
    a_aux: assert property (p_aux) else $error("aux data in single register mode");
    property p_xfer; image_gate_a && storage_gate |=> !image_gate_a; endproperty
    a_xfer: assert property (p_xfer) else $error("transfer pulse too long");
    c_dual: cover property (out_valid && mode_q == 2'h2);
    c_stall: cover property (out_valid && !out_ready);
    c_sum: cover property (image_gate_a && !storage_gate);
endmodule
bind ccdr_ctrl ccdr_ctrl_checker #(.AW(AW)) chk_u (.ref_clk(ref_clk), .srst(srst),
    .frame_start(frame_start), .mode_sel(mode_sel), .out_ready(out_ready),
    .image_gate_a(image_gate_a), .storage_gate(storage_gate),
    .serial_shift_gate(serial_shift_gate), .reset_gate(reset_gate),
    .drain_clear(drain_clear), .drain_dip(drain_dip), .out_valid(out_valid),
    .out_video(out_video), .out_aux(out_aux), .busy(busy));
`default_nettype wire

// ### ccdr_sensor_model.sv
/*
 * Behavioural sensor: turns gate drive into converter samples.
 * Assumes a 12-bit converter behind each output amplifier.
 */
`default_nettype none
module ccdr_sensor_model (
    input  wire logic   ref_clk,
    input  wire logic   storage_gate,
    input  wire logic   serial_shift_gate,
    output logic [11:0] adc_a,
    output logic [11:0] adc_b
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DUMMY = 4;
    localparam int DARK = 22;
    int idx;
    // every line move, dark rows alike
    always @(posedge ref_clk) begin
        if (storage_gate) idx <= 0;
        else if (serial_shift_gate) idx <= idx + 1;
    end
    always_comb begin
        if (idx <= DUMMY) begin
            adc_a = 12'h3FF;
            adc_b = 12'h3FF;
        end else if (idx <= DUMMY + DARK) begin
            adc_a = 12'h400;
            adc_b = 12'h800;
        end else begin
            adc_a = 12'h400 | {2'h0, idx[9:0]};
            adc_b = 12'hC00 | {2'h0, idx[9:0]};
        end
    end
endmodule
`default_nettype wire

// ### ccd_frame_transfer_readout_bench.sv
/*
 * Self-checking bench for the sequencer with a sensor model.
 * Assumes shortened geometry: 8 lines, 30 pixels, 20 cycles of integration.
 */
`default_nettype none
module ccd_frame_transfer_readout_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int L = 8;
    logic ref_clk = 0, srst = 1, frame_start = 0, out_ready = 1, stall = 0;
    logic [1:0] mode_sel = 2'h0, cur_mode = 2'h0;
    logic [11:0] adc_a, adc_b, out_video, out_aux;
    logic ga, gb, sg, ssg, rg, dc, dd, out_valid, out_dark, ls, busy, xf_q = 0;
    int fails = 0, compares = 0, cyc = 0, lines_n, dark_n, xfer_n, field = 0;
    logic [1:0] row_mode [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    int row_lines [5] = '{L + 4, L + 4, (L + 4) / 2, L + 4, L + 4};
    ccdr_ctrl #(.AW(12), .LINES(L), .PIXELS(30), .INTEG_CY(20)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .frame_start(frame_start), .mode_sel(mode_sel),
        .adc_a(adc_a), .adc_b(adc_b), .out_ready(out_ready), .image_gate_a(ga),
        .image_gate_b(gb), .storage_gate(sg), .serial_shift_gate(ssg), .reset_gate(rg),
        .drain_clear(dc), .drain_dip(dd), .out_valid(out_valid), .out_video(out_video),
        .out_aux(out_aux), .out_dark(out_dark), .out_line_start(ls), .busy(busy));
    ccdr_sensor_model sens_u (.ref_clk(ref_clk), .storage_gate(sg),
        .serial_shift_gate(ssg), .adc_a(adc_a), .adc_b(adc_b));
    always #20 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_of_test();
        end
        if (ga && sg && !xf_q) xfer_n++;
        xf_q = ga && sg;
        if (out_valid && out_ready) begin
            lines_n += ls;
            dark_n += out_dark;
            if (out_dark) check(out_video, 12'h800);
            else check({out_video[11:10], 10'h0}, 12'hC00);
            if (cur_mode == 2'h2) check({out_aux[11:10], 10'h0}, 12'h400);
        end
        #1 out_ready = !(stall || cyc % 5 == 0);
    end
    // Awkward frame: restart and mode change mid-run, long downstream stall
    task automatic run_frame(input logic [1:0] m, input int lines, input bit awk);
        int t;
        @(posedge ref_clk);
        #1 mode_sel = m;
        cur_mode = m;
        frame_start = 1;
        lines_n = 0;
        dark_n = 0;
        xfer_n = 0;
        @(posedge ref_clk);
        #1 frame_start = 0;
        if (awk) begin
            repeat (100) @(posedge ref_clk);
            #1 frame_start = 1;
            mode_sel = 2'h2;
            stall = 1;
            @(posedge ref_clk);
            #1 frame_start = 0;
            repeat (300) @(posedge ref_clk);
            stall = 0;
        end
        t = 0;
        while (busy !== 1'b0 && t < 20000) begin
            @(posedge ref_clk);
            t++;
        end
        repeat (40) @(posedge ref_clk);
        check(lines_n, lines);
        check(dark_n, 22 * lines);
        check(xfer_n, L + field);
        check(busy, 0);
        field ^= 1;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 srst = 0;
        check({busy, dc, out_valid, ga, gb, sg, ssg, rg}, 0);
        for (int i = 0; i < 5; i++) run_frame(row_mode[i], row_lines[i], 0);
        run_frame(2'h0, L + 4, 1);
        end_of_test();
    end
endmodule
`default_nettype wire
